// ### trb_top.sv
`timescale 1ns/1ns
module trb_top
  import trb_pkg::*;
#(
  parameter logic [2:0] MAX_CODE = DEPTH_CODE_MAX
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  input  wire logic            ce,
  // register access
  input  wire logic            csr_req,
  input  wire logic            csr_write,
  input  wire logic [3:0]      csr_code,
  input  wire logic            csr_guest,
  input  wire logic [XW-1:0]   csr_wdata,
  input  wire logic            cur_rv32,
  output logic                 csr_ack_ff,
  output logic [XW-1:0]        csr_rdata_ff,
  // recording
  input  wire logic            priv_enabled,
  input  wire logic            return_stack_emulation,
  input  wire logic            rec_push,
  input  wire logic            rec_pop,
  input  wire logic            freeze_set,
  input  wire logic [XW-1:0]   rec_source,
  input  wire logic [XW-1:0]   rec_target,
  input  wire logic [XW-1:0]   rec_data,
  // state view
  output logic                 frozen_ff,
  output logic [PW-1:0]        write_pointer_ff,
  output logic [2:0]           depth_code_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [SEL_W-1:0] sel_ff;
  logic [SEL_W-1:0] gsel_ff;
  logic [255:0]     valid_ff;
  logic             rd1_ff;
  logic [3:0]       code1_ff;
  logic             inrec1_ff;
  logic             rv32_1_ff;
  logic             valid1_ff;
  logic [XW-1:0]    plain1_ff;
  logic             ack1_ff;

  logic [PW-1:0]    mask;
  logic [PW-1:0]    nxt_mask;
  logic [2:0]       nxt_depth_code;
  logic [PW-1:0]    nxt_write_pointer;
  logic             nxt_frozen;
  logic             active;
  logic             do_push;
  logic             do_pop;
  logic [SEL_W-1:0] eff_sel;
  logic             in_bank;
  logic [PW-1:0]    slot;
  logic             in_range;
  logic             rec_hit;
  logic             is_win;
  logic             sw_wr;
  logic [XW-1:0]    sw_data;
  logic [XW-1:0]    hw_src;
  logic [XW-1:0]    status_word;
  logic [XW-1:0]    win_data;
  logic [PW-1:0]    pop_slot;

  trb_mem_if #(.AW(PW), .FW(XW), .NF(NFIELD)) mif ();

  ////////////////////////////////////////////////////////////////////////////
  // depth decode
  function automatic logic [PW-1:0] depth_mask(input logic [2:0] code);
    logic [PW-1:0] mk;
    mk = 8'h0f;
    case (code)
      3'h0:    mk = 8'h0f;
      3'h1:    mk = 8'h1f;
      3'h2:    mk = 8'h3f;
      3'h3:    mk = 8'h7f;
      3'h4:    mk = 8'hff;
      default: mk = 8'h0f;
    endcase
    return mk;
  endfunction

  assign mask = depth_mask(depth_code_ff);

  ////////////////////////////////////////////////////////////////////////////
  // recording qualification
  always_comb begin
    active  = priv_enabled && !frozen_ff;
    do_push = active && rec_push;
    do_pop  = active && rec_pop && return_stack_emulation && !rec_push;
    // narrow mode zero-extends the captured source, bit 0 stored as zero (valid kept in valid_ff)
    hw_src  = cur_rv32 ? {32'h0000_0000, rec_source[31:1], 1'b0}
                       : {rec_source[XW-1:1], 1'b0};
    pop_slot = PW'(write_pointer_ff - PW'(1)) & mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect selection and mapping
  always_comb begin
    // separate select registers, one shared storage
    eff_sel = csr_guest ? gsel_ff : sel_ff;
    in_bank = eff_sel[SEL_W-1:PW] == REC_BANK;
    is_win  = (csr_code >= CSR_WIN1) && (csr_code <= CSR_WIN6);
    rec_hit = in_bank && in_range;
  end

  trb_slot_map #(.PW(PW)) u_map (
    .write_pointer    (write_pointer_ff),
    .mask     (mask),
    .logical  (eff_sel[PW-1:0]),
    .slot     (slot),
    .in_range (in_range)
  );

  ////////////////////////////////////////////////////////////////////////////
  // software write decode
  always_comb begin
    sw_data = cur_rv32 ? {32'h0000_0000, csr_wdata[31:0]} : csr_wdata;
    // hardware recording owns the single write port in its cycle
    sw_wr   = csr_req && csr_write && is_win && rec_hit && !do_push;
  end

  ////////////////////////////////////////////////////////////////////////////
  // record storage port
  always_comb begin
    mif.raddr = slot;
    mif.we    = '0;
    mif.waddr = slot;
    mif.wdata = {sw_data, sw_data, {sw_data[XW-1:1], 1'b0}};
    if (do_push) begin
      mif.we    = '1;
      mif.waddr = write_pointer_ff;
      mif.wdata = {rec_data, rec_target, hw_src};
    end else if (sw_wr) begin
      case (csr_code)
        CSR_WIN1: mif.we[FLD_SRC] = 1'b1;
        CSR_WIN2: mif.we[FLD_TGT] = 1'b1;
        CSR_WIN3: mif.we[FLD_DAT] = 1'b1;
        default:  mif.we = '0;
      endcase
    end
  end

  trb_rec_mem #(.AW(PW), .FW(XW), .NF(NFIELD)) u_mem (
    .mclk (mclk),
    .ce   (ce),
    .m    (mif.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // depth code
  always_comb begin
    nxt_depth_code = depth_code_ff;
    if (csr_req && csr_write && csr_code == CSR_DEPTH && csr_wdata[2:0] <= MAX_CODE) begin
      nxt_depth_code = csr_wdata[2:0];
    end
    nxt_mask = depth_mask(nxt_depth_code);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      depth_code_ff <= DEPTH_CODE_RST;
    end else if (ce) begin
      depth_code_ff <= nxt_depth_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write pointer
  always_comb begin
    nxt_write_pointer = write_pointer_ff;
    if (do_push) begin
      nxt_write_pointer = PW'(write_pointer_ff + PW'(1));
    end else if (do_pop) begin
      nxt_write_pointer = PW'(write_pointer_ff - PW'(1));
    end
    // software write wins over a same-cycle hardware step
    if (csr_req && csr_write && csr_code == CSR_STATUS) begin
      nxt_write_pointer = csr_wdata[WRITE_POINTER_MSB:WRITE_POINTER_LSB];
    end
    // masking with the new depth keeps wrap and a legal value after resize
    nxt_write_pointer = nxt_write_pointer & nxt_mask;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      write_pointer_ff <= WRITE_POINTER_RST;
    end else if (ce) begin
      write_pointer_ff <= nxt_write_pointer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // freeze flag
  always_comb begin
    nxt_frozen = frozen_ff;
    if (csr_req && csr_write && csr_code == CSR_STATUS) begin
      nxt_frozen = csr_wdata[FROZEN_BIT];
    end
    // a freeze event is never lost to a same-cycle software clear
    if (freeze_set) begin
      nxt_frozen = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frozen_ff <= 1'b0;
    end else if (ce) begin
      frozen_ff <= nxt_frozen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // valid flags
  // kept in flops beside the storage so that reset can clear them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_ff <= '0;
    end else if (ce) begin
      if (sw_wr && csr_code == CSR_WIN1) begin
        valid_ff[slot] <= sw_data[0];
      end
      if (do_push) begin
        valid_ff[write_pointer_ff] <= 1'b1;
      end else if (do_pop) begin
        valid_ff[pop_slot] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect select registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_ff  <= SELECT_RST;
      gsel_ff <= SELECT_RST;
    end else if (ce) begin
      if (csr_req && csr_write && csr_code == CSR_SELECT) begin
        if (csr_guest) begin
          gsel_ff <= csr_wdata[SEL_W-1:0];
        end else begin
          sel_ff <= csr_wdata[SEL_W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline, stage one waits for the storage read register
  always_comb begin
    status_word = '0;
    status_word[FROZEN_BIT] = frozen_ff;
    status_word[WRITE_POINTER_MSB:WRITE_POINTER_LSB] = write_pointer_ff & mask;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd1_ff    <= 1'b0;
      code1_ff  <= CSR_STATUS;
      inrec1_ff <= 1'b0;
      rv32_1_ff <= 1'b0;
      valid1_ff <= 1'b0;
      plain1_ff <= '0;
      ack1_ff   <= 1'b0;
    end else if (ce) begin
      ack1_ff   <= csr_req;
      rd1_ff    <= csr_req && !csr_write;
      code1_ff  <= csr_code;
      inrec1_ff <= rec_hit;
      rv32_1_ff <= cur_rv32;
      valid1_ff <= valid_ff[slot];
      case (csr_code)
        CSR_STATUS: plain1_ff <= status_word;
        CSR_DEPTH:  plain1_ff <= {61'h0, depth_code_ff};
        CSR_SELECT: plain1_ff <= {52'h0, eff_sel};
        default:    plain1_ff <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline, stage two picks the answer
  always_comb begin
    win_data = '0;
    // storage is never reset, so its read data shows only on a record hit
    if (inrec1_ff) begin
      case (code1_ff)
        CSR_WIN1: win_data = {mif.rdata[FLD_SRC*XW+1 +: XW-1], valid1_ff};
        CSR_WIN2: win_data = mif.rdata[FLD_TGT*XW +: XW];
        CSR_WIN3: win_data = mif.rdata[FLD_DAT*XW +: XW];
        default:  win_data = '0;
      endcase
    end
    if (code1_ff < CSR_WIN1) begin
      win_data = plain1_ff;
    end
    // narrow mode shows only the low 32 bits; narrow-mode writes were already stored zero-extended
    if (rv32_1_ff) begin
      win_data = {32'h0000_0000, win_data[31:0]};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      csr_ack_ff   <= 1'b0;
      csr_rdata_ff <= '0;
    end else if (ce) begin
      csr_ack_ff <= ack1_ff;
      if (rd1_ff) begin
        csr_rdata_ff <= win_data;
      end
    end
  end

endmodule

// ### trb_pkg.sv
package trb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int XW     = 64;
  localparam int PW     = 8;
  localparam int SEL_W  = 12;
  localparam int NFIELD = 3;

  ////////////////////////////////////////////////////////////////////////////
  // record status layout
  localparam int FROZEN_BIT = 31;
  localparam int WRITE_POINTER_MSB  = 7;
  localparam int WRITE_POINTER_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0]       DEPTH_CODE_RST = 3'h0;
  localparam logic [PW-1:0]    WRITE_POINTER_RST      = 8'h00;
  localparam logic [SEL_W-1:0] SELECT_RST     = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // depth codes
  localparam logic [2:0] DEPTH_CODE_MAX = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // indirect select bank holding the records (index bits 11:8)
  localparam logic [3:0] REC_BANK = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // register codes on the csr port
  localparam logic [3:0] CSR_STATUS = 4'h0;
  localparam logic [3:0] CSR_DEPTH  = 4'h1;
  localparam logic [3:0] CSR_SELECT = 4'h2;
  localparam logic [3:0] CSR_WIN1   = 4'h3;
  localparam logic [3:0] CSR_WIN2   = 4'h4;
  localparam logic [3:0] CSR_WIN3   = 4'h5;
  localparam logic [3:0] CSR_WIN6   = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // field index inside one record
  localparam int FLD_SRC = 0;
  localparam int FLD_TGT = 1;
  localparam int FLD_DAT = 2;

endpackage

// ### trb_mem_if.sv
`timescale 1ns/1ns
interface trb_mem_if #(
  parameter int AW = 8,
  parameter int FW = 64,
  parameter int NF = 3
);
  logic [NF-1:0]    we;
  logic [AW-1:0]    waddr;
  logic [NF*FW-1:0] wdata;
  logic [AW-1:0]    raddr;
  logic [NF*FW-1:0] rdata;

  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### trb_rec_mem.sv
`timescale 1ns/1ns
module trb_rec_mem #(
  parameter int AW = 8,
  parameter int FW = 64,
  parameter int NF = 3
) (
  // clock
  input wire logic mclk,
  input wire logic ce,
  // port
  trb_mem_if.mem   m
);

  // one array per field so each field writes alone without read-modify-write
  for (genvar f = 0; f < NF; f++) begin : g_fld
    logic [FW-1:0] store_ff [2**AW];
    logic [FW-1:0] rd_ff;

    always_ff @(posedge mclk) begin
      if (ce && m.we[f]) begin
        store_ff[m.waddr] <= m.wdata[f*FW +: FW];
      end
    end

    always_ff @(posedge mclk) begin
      if (ce) begin
        rd_ff <= store_ff[m.raddr];
      end
    end

    assign m.rdata[f*FW +: FW] = rd_ff;
  end

endmodule

// ### trb_slot_map.sv
`timescale 1ns/1ns
module trb_slot_map #(
  parameter int PW = 8
) (
  // pointer state
  input  wire logic [PW-1:0] write_pointer,
  input  wire logic [PW-1:0] mask,
  // logical record
  input  wire logic [PW-1:0] logical,
  output logic      [PW-1:0] slot,
  output logic               in_range
);

  always_comb begin
    slot     = PW'(write_pointer - logical - PW'(1)) & mask;
    in_range = (logical & ~mask) == '0;
  end

endmodule

// ### trb_top_asserts.sv
`timescale 1ns/1ns
module trb_top_asserts
  import trb_pkg::*;
#(
  parameter logic [2:0] MAX_CODE = DEPTH_CODE_MAX
) (
  // clock and reset
  input wire logic          mclk,
  input wire logic          arst_n,
  input wire logic          ce,
  // register access
  input wire logic          csr_req,
  input wire logic          csr_ack_ff,
  // recording
  input wire logic          priv_enabled,
  input wire logic          return_stack_emulation,
  input wire logic          rec_push,
  input wire logic          rec_pop,
  input wire logic          freeze_set,
  // state view
  input wire logic          frozen_ff,
  input wire logic [PW-1:0] write_pointer_ff,
  input wire logic [2:0]    depth_code_ff
);
  logic [PW-1:0] ptr_mask;
  logic          last_req_ff;
  logic          quiet;

  // a software access may move the pointer, so cycles next to one are excluded
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_req_ff <= 1'b0;
    end else begin
      last_req_ff <= csr_req;
    end
  end
  assign quiet    = !csr_req && !last_req_ff;
  assign ptr_mask = (8'h10 << depth_code_ff) - 8'h01;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  chk_ack_timing: assert property (ce && csr_req ##1 ce |-> ##1 csr_ack_ff)
    else $error("ack missing two cycles after request");
  chk_ack_cause: assert property (csr_ack_ff |-> $past(csr_req, 2))
    else $error("ack without request");
  chk_push_incr: assert property (ce && rec_push && priv_enabled && !frozen_ff && quiet
    |=> write_pointer_ff == (($past(write_pointer_ff) + 8'h01) & ptr_mask))
    else $error("pointer not advanced by push");
  chk_pop_decr: assert property (ce && rec_pop && !rec_push && return_stack_emulation
    && priv_enabled && !frozen_ff && quiet
    |=> write_pointer_ff == (($past(write_pointer_ff) - 8'h01) & ptr_mask))
    else $error("pointer not stepped back by pop");
  chk_frozen_hold: assert property (frozen_ff && quiet |=> $stable(write_pointer_ff))
    else $error("pointer moved while frozen");
  chk_idle_hold: assert property (!priv_enabled && quiet |=> $stable(write_pointer_ff))
    else $error("pointer moved while not enabled");
  chk_freeze_set: assert property (ce && freeze_set |=> frozen_ff)
    else $error("freeze event not taken");
  chk_ptr_legal: assert property ((write_pointer_ff & ~ptr_mask) == 8'h00)
    else $error("pointer beyond depth");
  chk_code_legal: assert property (depth_code_ff <= MAX_CODE)
    else $error("unsupported depth code held");
  chk_ce_hold: assert property (!ce |=> $stable(write_pointer_ff) && $stable(frozen_ff)
    && $stable(depth_code_ff))
    else $error("state moved while clock enable low");
endmodule

bind trb_top trb_top_asserts #(.MAX_CODE(MAX_CODE)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .ce(ce), .csr_req(csr_req), .csr_ack_ff(csr_ack_ff),
  .priv_enabled(priv_enabled), .return_stack_emulation(return_stack_emulation),
  .rec_push(rec_push), .rec_pop(rec_pop), .freeze_set(freeze_set), .frozen_ff(frozen_ff),
  .write_pointer_ff(write_pointer_ff), .depth_code_ff(depth_code_ff)
);

// ### test_trb_top.sv
`timescale 1ns/1ns
module test_trb_top
  import trb_pkg::*;
;
  logic          mclk, arst_n, ce, csr_req, csr_write, csr_guest, cur_rv32;
  logic [3:0]    csr_code;
  logic [XW-1:0] csr_wdata, csr_rdata_ff, rec_source, rec_target, rec_data;
  logic          csr_ack_ff, priv_enabled, return_stack_emulation, rec_push, rec_pop;
  logic          freeze_set, frozen_ff;
  logic [PW-1:0] write_pointer_ff;
  logic [2:0]    depth_code_ff;
  int            errors, comparisons, cycles;

  trb_top dut_u (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .csr_req(csr_req), .csr_write(csr_write),
    .csr_code(csr_code), .csr_guest(csr_guest), .csr_wdata(csr_wdata),
    .cur_rv32(cur_rv32), .csr_ack_ff(csr_ack_ff), .csr_rdata_ff(csr_rdata_ff),
    .priv_enabled(priv_enabled), .return_stack_emulation(return_stack_emulation),
    .rec_push(rec_push), .rec_pop(rec_pop), .freeze_set(freeze_set),
    .rec_source(rec_source), .rec_target(rec_target), .rec_data(rec_data),
    .frozen_ff(frozen_ff), .write_pointer_ff(write_pointer_ff),
    .depth_code_ff(depth_code_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one access; request dropped after one cycle as the port wants a pulse
  task automatic csr(input logic wr, input logic [3:0] code, input logic [63:0] wd,
                     output logic [63:0] rd);
    int n;
    n = 0;
    @(negedge mclk);
    csr_req   = 1'b1;
    csr_write = wr;
    csr_code  = code;
    csr_wdata = wd;
    @(negedge mclk);
    csr_req = 1'b0;
    while (csr_ack_ff !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    check("ack", {63'h0, csr_ack_ff}, 64'h1);
    rd = csr_rdata_ff;
  endtask

  task automatic wr(input logic [3:0] code, input logic [63:0] wd);
    logic [63:0] d;
    csr(1'b1, code, wd, d);
  endtask

  task automatic rd_chk(input logic [3:0] code, input logic [63:0] exp);
    logic [63:0] d;
    csr(1'b0, code, 64'h0, d);
    check($sformatf("read code %0h", code), d, exp);
  endtask

  task automatic push(input logic [63:0] src);
    @(negedge mclk);
    rec_push   = 1'b1;
    rec_source = src;
    rec_target = ~src;
    rec_data   = {src[31:0], src[63:32]};
    @(negedge mclk);
    rec_push = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ceiling well above the roughly 130 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 3000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    {arst_n, csr_req, csr_write, csr_guest, cur_rv32, priv_enabled} = 6'h00;
    {return_stack_emulation, rec_push, rec_pop, freeze_set} = 4'h0;
    {csr_code, csr_wdata, rec_source, rec_target, rec_data} = '0;
    {errors, comparisons, cycles} = '0;
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    rd_chk(CSR_STATUS, 64'h0);
    wr(CSR_DEPTH, 64'h5);
    rd_chk(CSR_DEPTH, 64'h0);
    wr(CSR_DEPTH, 64'h1);
    rd_chk(CSR_DEPTH, 64'h1);
    check("depth_code", {61'h0, depth_code_ff}, 64'h1);
    wr(CSR_DEPTH, 64'h0);
    push(64'h0123_4567_89ab_cdef);
    rd_chk(CSR_STATUS, 64'h0);
    priv_enabled = 1'b1;
    push(64'hfedc_ba98_7654_3210);
    rd_chk(CSR_STATUS, 64'h1);
    check("write_pointer", {56'h0, write_pointer_ff}, 64'h1);
    wr(CSR_SELECT, 64'h200);
    rd_chk(CSR_WIN1, 64'hfedc_ba98_7654_3211);
    rd_chk(CSR_WIN2, 64'h0123_4567_89ab_cdef);
    rd_chk(CSR_WIN3, 64'h7654_3210_fedc_ba98);
    for (int c = 6; c <= 8; c++) rd_chk(c[3:0], 64'h0);
    // normal select points out of range, so only the guest select can hit
    wr(CSR_SELECT, 64'h210);
    csr_guest = 1'b1;
    wr(CSR_SELECT, 64'h200);
    rd_chk(CSR_SELECT, 64'h200);
    rd_chk(CSR_WIN1, 64'hfedc_ba98_7654_3211);
    csr_guest = 1'b0;
    push(64'h1111_2222_3333_4444);
    wr(CSR_SELECT, 64'h201);
    rd_chk(CSR_WIN1, 64'hfedc_ba98_7654_3211);
    wr(CSR_SELECT, 64'h210);
    rd_chk(CSR_WIN1, 64'h0);
    wr(CSR_STATUS, 64'hffff_ffff_7fff_fff5);
    rd_chk(CSR_STATUS, 64'h5);
    wr(CSR_STATUS, 64'hf);
    push(64'h5555_6666_7777_8888);
    rd_chk(CSR_STATUS, 64'h0);
    return_stack_emulation = 1'b1;
    @(negedge mclk) rec_pop = 1'b1;
    @(negedge mclk) rec_pop = 1'b0;
    rd_chk(CSR_STATUS, 64'hf);
    @(negedge mclk) freeze_set = 1'b1;
    @(negedge mclk) freeze_set = 1'b0;
    push(64'h9999_aaaa_bbbb_cccc);
    rd_chk(CSR_STATUS, 64'h8000_000f);
    check("frozen", {63'h0, frozen_ff}, 64'h1);
    wr(CSR_STATUS, 64'h0);
    rd_chk(CSR_STATUS, 64'h0);
    // clock enable low must swallow a push
    @(negedge mclk) ce = 1'b0;
    push(64'h2222_3333_4444_5555);
    check("write_pointer", {56'h0, write_pointer_ff}, 64'h0);
    @(negedge mclk) ce = 1'b1;
    wr(CSR_SELECT, 64'h200);
    cur_rv32 = 1'b1;
    wr(CSR_WIN1, 64'hffff_ffff_1234_5679);
    cur_rv32 = 1'b0;
    rd_chk(CSR_WIN1, 64'h0000_0000_1234_5679);
    wr(CSR_WIN1, 64'hfedc_ba98_7654_3211);
    cur_rv32 = 1'b1;
    rd_chk(CSR_WIN1, 64'h0000_0000_7654_3211);
    cur_rv32 = 1'b0;
    rd_chk(CSR_WIN1, 64'hfedc_ba98_7654_3211);
    stop_test();
  end
endmodule
